// ==== sbcs_ctrl_model.sv ====
// memory controller model driving the device command pins
// assumes callers step time 1 ns after a rising edge
module sbcs_ctrl_model
  import sbcs_pkg::*;
(
  input wire logic sys_clk,
  output sbcs_cmd_pins_t cmd_pins,
  output logic clock_enable,
  output logic data_mask,
  output logic [SBCS_DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  sbcs_cmd_pins_t req_pins; // pending command
  logic [SBCS_DATA_W-1:0] req_data; // pending word
  logic pend = 1'b0; // command waiting for an edge
  logic cke_req = 1'b1; // clock enable wanted
  logic mask_req = 1'b0; // mask wanted
  initial begin
    cmd_pins = {4'h7, 2'h0, 12'h000};
    clock_enable = 1'b1;
    data_mask = 1'b0;
    data_in = 16'h0000;
  end
  // ============================================================
  // pin driver
  // nop when idle
  always @(posedge sys_clk) begin
    clock_enable <= cke_req;
    data_mask <= mask_req;
    if (pend) begin
      cmd_pins <= req_pins;
      data_in <= req_data;
      pend = 1'b0;
    end else begin
      cmd_pins <= {4'h7, 2'h0, 12'h000};
      data_in <= ~data_in;
    end
  end
  task automatic issue(input logic [3:0] enc, input logic [1:0] bank, input logic [11:0] addr,
    input logic [15:0] data = 16'h0000);
    req_pins = {enc, bank, addr};
    req_data = data;
    pend = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask
endmodule

// ==== sbcs_device.sv ====
// ============================================================
// sdram bank command state tracker, device side
// ============================================================
// holds per-bank state, clock enable modes and the data pin engine.
// assumes command pins, clock enable and data come from the controller
// through pins; each passes a two-stage synchroniser before use.
module sbcs_device
  import sbcs_pkg::*;
#(
  parameter int READ_LATENCY = SBCS_READ_LATENCY,
  parameter int BURST_LEN = SBCS_BURST_LEN
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire sbcs_cmd_pins_t cmd_pins, // command and address pins
  input wire logic clock_enable, // clock enable pin
  input wire logic data_mask, // write mask, read output disable
  input wire logic [SBCS_DATA_W-1:0] data_in, // data pins, input side
  output logic [SBCS_DATA_W-1:0] data_out, // data pins, output side
  output logic data_oe_n, // low while the device drives data
  output logic wr_strobe, // one word written this cycle
  output logic [SBCS_BANK_W-1:0] wr_bank, // bank of the written word
  output logic [SBCS_DATA_W-1:0] wr_data, // the written word
  output logic illegal_cmd, // sticky-free pulse on a reserved combination
  output logic all_idle, // every bank idle and device running
  output logic [2:0] mode_code // current clock enable mode
);

  // ============================================================
  // input synchronisers
  // ============================================================
  localparam int IN_W = $bits(sbcs_cmd_pins_t) + 2 + SBCS_DATA_W;
  // pins deselected and clock enable high, so reset leaves no false clock enable edge
  localparam logic [IN_W-1:0] SYNC_IDLE = {4'hf, {(SBCS_BANK_W + SBCS_ADDR_W){1'b0}}, 1'b1,
    1'b0, {SBCS_DATA_W{1'b0}}};
  logic [IN_W-1:0] sync1_reg; // first stage, read only by stage two
  logic [IN_W-1:0] sync2_reg; // second stage
  sbcs_cmd_pins_t pins;
  logic cke;
  logic dqm;
  logic [SBCS_DATA_W-1:0] din;

  // two flops on every pin input
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= {cmd_pins, clock_enable, data_mask, data_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign {pins, cke, dqm, din} = sync2_reg;

  // ============================================================
  // decode
  // ============================================================
  sbcs_cmd_t cmd;
  logic ap_flag;
  logic [SBCS_BANK_W-1:0] cb;
  logic cke_prev_reg; // clock enable at previous edge
  sbcs_mode_t mode_reg;
  logic [SBCS_CNT_W-1:0] xsr_cnt_reg; // self refresh exit count
  logic run; // bank rules apply this edge
  assign cmd = sbcs_decode(pins);
  assign ap_flag = pins.addr[SBCS_AP_BIT];
  assign cb = pins.bank;
  assign run = cke_prev_reg && cke && (mode_reg == SBCS_MODE_RUN);

  // ============================================================
  // bank state storage
  // ============================================================
  sbcs_bank_t bank_reg [SBCS_NUM_BANKS]; // state of each bank
  logic [SBCS_CNT_W-1:0] tcnt_reg [SBCS_NUM_BANKS]; // state timers
  logic any_idle_only;

  // all banks idle, used by mode changes
  always_comb begin
    any_idle_only = 1'b1;
    for (int i = 0; i < SBCS_NUM_BANKS; i++) begin
      if (bank_reg[i] != SBCS_BK_IDLE) begin
        any_idle_only = 1'b0;
      end
    end
  end

  // burst engine state, single burst in flight
  logic burst_rd_reg; // a read burst is running
  logic burst_wr_reg; // a write burst is running
  logic [SBCS_BANK_W-1:0] burst_bank_reg; // bank owning the burst
  logic [SBCS_CNT_W-1:0] burst_left_reg; // words left in the burst
  logic access; // legal read or write registers this edge
  logic is_read;
  logic illegal_next; // reserved combination seen this edge
  logic frozen; // suspended internal edge
  // a refused access must not start a burst or cut another bank's burst
  assign access = run && (cmd == SBCS_CMD_RD || cmd == SBCS_CMD_WR) && !illegal_next;
  assign is_read = (cmd == SBCS_CMD_RD);

  // ============================================================
  // clock enable modes
  // ============================================================
  // mode transitions on clock enable edges; the exit wait ends on its own count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cke_prev_reg <= 1'b1;
      mode_reg <= SBCS_MODE_RUN;
      xsr_cnt_reg <= '0;
    end else begin
      cke_prev_reg <= cke;
      case (mode_reg)
        SBCS_MODE_RUN: begin
          if (cke_prev_reg && !cke) begin
            if (any_idle_only && (cmd == SBCS_CMD_NOP || cmd == SBCS_CMD_INHIBIT)) begin
              mode_reg <= SBCS_MODE_POWER_DOWN;
            end else if (any_idle_only && cmd == SBCS_CMD_REF) begin
              mode_reg <= SBCS_MODE_SELF_REFRESH;
            end else if ((burst_rd_reg || burst_wr_reg) &&
                         (cmd == SBCS_CMD_WR || cmd == SBCS_CMD_NOP)) begin
              mode_reg <= SBCS_MODE_SUSPEND;
            end
          end
        end
        SBCS_MODE_POWER_DOWN: begin
          // exit needs nop or inhibit with clock enable high
          if (cke && (cmd == SBCS_CMD_NOP || cmd == SBCS_CMD_INHIBIT)) begin
            mode_reg <= SBCS_MODE_RUN;
          end
        end
        SBCS_MODE_SELF_REFRESH: begin
          if (cke && (cmd == SBCS_CMD_NOP || cmd == SBCS_CMD_INHIBIT)) begin
            mode_reg <= SBCS_MODE_XSR_WAIT;
            xsr_cnt_reg <= SBCS_CNT_W'(SBCS_XSR_CYC);
          end
        end
        SBCS_MODE_SUSPEND: begin
          if (cke) begin
            mode_reg <= SBCS_MODE_RUN;
          end
        end
        SBCS_MODE_XSR_WAIT: begin
          // wait out exit time; controller sends nops meanwhile
          if (xsr_cnt_reg <= SBCS_CNT_W'(1)) begin
            mode_reg <= SBCS_MODE_RUN;
          end else begin
            xsr_cnt_reg <= xsr_cnt_reg - SBCS_CNT_W'(1);
          end
        end
        default: mode_reg <= SBCS_MODE_RUN;
      endcase
    end
  end

  // ============================================================
  // per-bank state machines
  // ============================================================
  // each bank advances on its own timer and on commands to any bank
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < SBCS_NUM_BANKS; i++) begin
        bank_reg[i] <= SBCS_BK_IDLE;
        tcnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < SBCS_NUM_BANKS; i++) begin
        // timers run down regardless of commands
        if (tcnt_reg[i] != '0) begin
          tcnt_reg[i] <= tcnt_reg[i] - SBCS_CNT_W'(1);
        end
        case (bank_reg[i])
          // activating ends row active after delay
          SBCS_BK_ACTIVATING: begin
            if (tcnt_reg[i] <= SBCS_CNT_W'(1)) begin
              bank_reg[i] <= SBCS_BK_ACTIVE;
            end
          end
          SBCS_BK_PRECHARGING: begin
            if (tcnt_reg[i] <= SBCS_CNT_W'(1)) begin
              bank_reg[i] <= SBCS_BK_IDLE;
            end
          end
          SBCS_BK_RECOVER: begin
            if (tcnt_reg[i] <= SBCS_CNT_W'(1)) begin
              bank_reg[i] <= SBCS_BK_PRECHARGING;
              tcnt_reg[i] <= SBCS_CNT_W'(SBCS_PRECHARGE_CYC);
            end
          end
          default: begin
          end
        endcase
        // burst ran out on its own
        if (!frozen && burst_left_reg == SBCS_CNT_W'(1) && burst_bank_reg == i[SBCS_BANK_W-1:0]
            && !access) begin
          if (bank_reg[i] == SBCS_BK_READ || bank_reg[i] == SBCS_BK_WRITE) begin
            bank_reg[i] <= SBCS_BK_ACTIVE;
          end else if (bank_reg[i] == SBCS_BK_READ_AP) begin
            bank_reg[i] <= SBCS_BK_PRECHARGING;
            tcnt_reg[i] <= SBCS_CNT_W'(SBCS_PRECHARGE_CYC);
          end else if (bank_reg[i] == SBCS_BK_WRITE_AP) begin
            bank_reg[i] <= SBCS_BK_RECOVER;
            tcnt_reg[i] <= SBCS_CNT_W'(SBCS_WR_CYC);
          end
        end
        // access to another bank ends an auto precharge burst here
        if (access && cb != i[SBCS_BANK_W-1:0]) begin
          if (bank_reg[i] == SBCS_BK_READ_AP) begin
            // precharge begins as the new command registers
            bank_reg[i] <= SBCS_BK_PRECHARGING;
            tcnt_reg[i] <= SBCS_CNT_W'(SBCS_PRECHARGE_CYC);
          end else if (bank_reg[i] == SBCS_BK_WRITE_AP) begin
            // recovery counted from the new command
            bank_reg[i] <= SBCS_BK_RECOVER;
            tcnt_reg[i] <= SBCS_CNT_W'(SBCS_WR_CYC);
          end else if (bank_reg[i] == SBCS_BK_READ || bank_reg[i] == SBCS_BK_WRITE) begin
            bank_reg[i] <= SBCS_BK_ACTIVE;
          end
        end
        // commands addressed to this bank (or all banks)
        if (run && (cb == i[SBCS_BANK_W-1:0] || (cmd == SBCS_CMD_PRE && ap_flag))) begin
          case (cmd)
            SBCS_CMD_ACT: begin
              if (bank_reg[i] == SBCS_BK_IDLE) begin
                bank_reg[i] <= SBCS_BK_ACTIVATING;
                tcnt_reg[i] <= SBCS_CNT_W'(SBCS_RCD_CYC);
              end
            end
            SBCS_CMD_RD, SBCS_CMD_WR: begin
              if (bank_reg[i] == SBCS_BK_ACTIVE || bank_reg[i] == SBCS_BK_READ ||
                  bank_reg[i] == SBCS_BK_WRITE) begin
                if (is_read) begin
                  bank_reg[i] <= ap_flag ? SBCS_BK_READ_AP : SBCS_BK_READ;
                end else begin
                  bank_reg[i] <= ap_flag ? SBCS_BK_WRITE_AP : SBCS_BK_WRITE;
                end
              end
            end
            SBCS_CMD_PRE: begin
              if (bank_reg[i] == SBCS_BK_ACTIVE || bank_reg[i] == SBCS_BK_READ ||
                  bank_reg[i] == SBCS_BK_WRITE) begin
                bank_reg[i] <= SBCS_BK_PRECHARGING;
                tcnt_reg[i] <= SBCS_CNT_W'(SBCS_PRECHARGE_CYC);
              end
            end
            SBCS_CMD_BT: begin
              if (bank_reg[i] == SBCS_BK_READ || bank_reg[i] == SBCS_BK_WRITE) begin
                bank_reg[i] <= SBCS_BK_ACTIVE;
              end
            end
            default: begin
              // nop and inhibit continue previous operation
            end
          endcase
        end
      end
    end
  end

  // ============================================================
  // legality check
  // ============================================================
  sbcs_bank_t tb;
  // flag combinations outside the allowed set
  always_comb begin
    illegal_next = 1'b0;
    tb = bank_reg[cb];
    if (run) begin
      case (cmd)
        SBCS_CMD_ACT: illegal_next = (tb != SBCS_BK_IDLE);
        SBCS_CMD_RD, SBCS_CMD_WR: illegal_next = !(tb == SBCS_BK_ACTIVE ||
          tb == SBCS_BK_READ || tb == SBCS_BK_WRITE);
        SBCS_CMD_REF, SBCS_CMD_LMR: illegal_next = !any_idle_only;
        SBCS_CMD_BT: illegal_next = !(burst_rd_reg || burst_wr_reg) ||
          tb == SBCS_BK_READ_AP || tb == SBCS_BK_WRITE_AP;
        SBCS_CMD_PRE: illegal_next = (tb == SBCS_BK_ACTIVATING || tb == SBCS_BK_READ_AP ||
          tb == SBCS_BK_WRITE_AP || tb == SBCS_BK_PRECHARGING || tb == SBCS_BK_RECOVER);
        default: illegal_next = 1'b0;
      endcase
    end
  end

  // registered illegal flag and status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      illegal_cmd <= 1'b0;
      all_idle <= 1'b1;
      mode_code <= 3'h0;
    end else begin
      illegal_cmd <= illegal_next;
      all_idle <= any_idle_only && (mode_reg == SBCS_MODE_RUN);
      mode_code <= 3'(mode_reg);
    end
  end

  // ============================================================
  // burst engine and data pins
  // ============================================================
  // read data pipe: one slot per latency cycle, valid plus word
  logic [READ_LATENCY-1:0] rd_pipe_reg;
  logic [SBCS_DATA_W-1:0] rd_word_reg; // next word pattern from address
  logic [SBCS_DATA_W-1:0] rd_dpipe_reg [READ_LATENCY]; // words in step with the valid slots
  // a low clock enable suspends the next edge; the entry edge itself still runs
  assign frozen = (mode_reg == SBCS_MODE_SUSPEND);

  // burst tracking and read pipeline
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      burst_rd_reg <= 1'b0;
      burst_wr_reg <= 1'b0;
      burst_bank_reg <= '0;
      burst_left_reg <= '0;
      rd_pipe_reg <= '0;
      rd_word_reg <= '0;
      for (int k = 0; k < READ_LATENCY; k++) begin
        rd_dpipe_reg[k] <= '0;
      end
    end else if (!frozen) begin
      rd_pipe_reg <= {rd_pipe_reg[READ_LATENCY-2:0], burst_rd_reg};
      // word pipe moves with the valid pipe so each word meets its own slot
      rd_dpipe_reg[0] <= rd_word_reg;
      for (int k = 1; k < READ_LATENCY; k++) begin
        rd_dpipe_reg[k] <= rd_dpipe_reg[k-1];
      end
      if (burst_rd_reg) begin
        rd_word_reg <= rd_word_reg + SBCS_DATA_W'(1);
      end
      if (access) begin
        // new command cuts the old burst at registration
        burst_rd_reg <= is_read;
        burst_wr_reg <= !is_read;
        burst_bank_reg <= cb;
        burst_left_reg <= SBCS_CNT_W'(is_read ? BURST_LEN : BURST_LEN - 1);
        rd_word_reg <= SBCS_DATA_W'(pins.addr);
        if (!is_read) begin
          // a write drops queued read words at once
          rd_pipe_reg <= '0;
        end
      end else if (run && (cmd == SBCS_CMD_BT || (cmd == SBCS_CMD_PRE &&
                   (cb == burst_bank_reg || ap_flag)))) begin
        burst_rd_reg <= 1'b0;
        burst_wr_reg <= 1'b0;
        burst_left_reg <= '0;
      end else if (burst_left_reg != '0) begin
        burst_left_reg <= burst_left_reg - SBCS_CNT_W'(1);
        if (burst_left_reg == SBCS_CNT_W'(1)) begin
          burst_rd_reg <= 1'b0;
          burst_wr_reg <= 1'b0;
        end
      end
    end
  end

  // read words leave read_latency after their slot, and stop likewise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else if (!frozen) begin
      data_out <= rd_dpipe_reg[READ_LATENCY-1];
      // mask disables output; the controller uses it ahead of a write
      data_oe_n <= !(rd_pipe_reg[READ_LATENCY-1] && !dqm);
    end
  end

  // write words: first with the command, then each edge of the burst
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_strobe <= 1'b0;
      wr_bank <= '0;
      wr_data <= '0;
    end else begin
      wr_strobe <= 1'b0;
      if (!frozen && !dqm) begin
        if (access && !is_read) begin
          wr_strobe <= 1'b1;
          wr_bank <= cb;
          wr_data <= din;
        end else if (burst_wr_reg && burst_left_reg != '0 && !access &&
                     !(run && (cmd == SBCS_CMD_BT || cmd == SBCS_CMD_PRE))) begin
          // a registering read stops the write; last word was a clock earlier
          wr_strobe <= 1'b1;
          wr_bank <= burst_bank_reg;
          wr_data <= din;
        end
      end
    end
  end

endmodule

// ==== sbcs_device_sva.sv ====
// checker for the sdram bank command state tracker
// assumes one clock, synchronous reset, bound into sbcs_device
module sbcs_device_sva
  import sbcs_pkg::*;
#(
  parameter int READ_LATENCY = SBCS_READ_LATENCY,
  parameter int BURST_LEN = SBCS_BURST_LEN
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [SBCS_DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic wr_strobe,
  input wire logic illegal_cmd,
  input wire logic all_idle,
  input wire logic [2:0] mode_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_reset_idle_out: assert property ($past(srst) |-> all_idle && mode_code == 3'h0 && data_oe_n)
    else $error("outputs not idle after reset");
  a_idle_means_run: assert property (all_idle |-> mode_code == 3'h0)
    else $error("idle flag outside run mode");
  a_mode_code_legal: assert property (mode_code <= 3'h4)
    else $error("mode code out of range");
  a_selfref_exit_path: assert property (mode_code == 3'h2 |=> mode_code inside {3'h2, 3'h4})
    else $error("self refresh left without exit wait");
  a_exit_wait_bound: assert property ($rose(mode_code == 3'h4) |-> ##[1:8] mode_code == 3'h0)
    else $error("exit wait too long");
  a_pd_exit_idle: assert property (mode_code == 3'h1 ##1 mode_code == 3'h0 |-> ##[0:2] all_idle)
    else $error("power-down exit not idle");
  a_pd_entry_idle: assert property ($rose(mode_code == 3'h1) |-> $past(all_idle))
    else $error("power-down entered while busy");
  a_suspend_hold: assert property (mode_code == 3'h3 && $past(mode_code) == 3'h3 |->
    $stable(data_out) && $stable(data_oe_n))
    else $error("outputs moved in suspend");
  a_no_rw_overlap: assert property (!data_oe_n |-> !wr_strobe)
    else $error("read drive during write");
  // main scenarios reached
  c_power_down: cover property (mode_code == 3'h1);
  c_exit_wait: cover property (mode_code == 3'h4);
  c_suspend: cover property (mode_code == 3'h3);
  c_illegal: cover property (illegal_cmd);
endmodule

bind sbcs_device sbcs_device_sva #(.READ_LATENCY(READ_LATENCY), .BURST_LEN(BURST_LEN)) u_sva (
  .sys_clk(sys_clk), .srst(srst), .data_out(data_out), .data_oe_n(data_oe_n),
  .wr_strobe(wr_strobe), .illegal_cmd(illegal_cmd), .all_idle(all_idle),
  .mode_code(mode_code));

// ==== sbcs_pkg.sv ====
// ============================================================
// package for the sdram bank command state tracker
// ============================================================
// holds command encodings, bank states, timing constants and carriers.
// assumes a single 40 MHz clock, period 25 ns.
package sbcs_pkg;

  // ============================================================
  // clock and timing
  // ============================================================
  localparam int SBCS_CLK_PERIOD_PS = 25000; // 40 MHz system clock
  localparam int SBCS_PRECHARGE_PERIOD_PS = 20000; // least time
  localparam int SBCS_ROW_TO_COLUMN_DELAY_PS = 20000; // least time
  localparam int SBCS_WRITE_RECOVERY_TIME_PS = 15000; // least time
  localparam int SBCS_SELF_REFRESH_EXIT_TIME_PS = 75000; // least time
  // least times round up to whole cycles, never below one
  localparam int SBCS_PRECHARGE_CYC =
    (SBCS_PRECHARGE_PERIOD_PS + SBCS_CLK_PERIOD_PS - 1) / SBCS_CLK_PERIOD_PS;
  localparam int SBCS_RCD_CYC =
    (SBCS_ROW_TO_COLUMN_DELAY_PS + SBCS_CLK_PERIOD_PS - 1) / SBCS_CLK_PERIOD_PS;
  localparam int SBCS_WR_CYC =
    (SBCS_WRITE_RECOVERY_TIME_PS + SBCS_CLK_PERIOD_PS - 1) / SBCS_CLK_PERIOD_PS;
  localparam int SBCS_XSR_CYC =
    (SBCS_SELF_REFRESH_EXIT_TIME_PS + SBCS_CLK_PERIOD_PS - 1) / SBCS_CLK_PERIOD_PS;
  localparam int SBCS_READ_LATENCY = 2; // default read latency in cycles
  localparam int SBCS_BURST_LEN = 4; // default burst length
  localparam int SBCS_CNT_W = 8; // width of every timing counter
  localparam int SBCS_NUM_BANKS = 4;
  localparam int SBCS_BANK_W = 2;
  localparam int SBCS_ADDR_W = 12;
  localparam int SBCS_DATA_W = 16;
  localparam int SBCS_AP_BIT = 10; // auto precharge / all banks address bit

  // ============================================================
  // commands: {sel_n, ras_n, cas_n, we_n} when sel_n low
  // ============================================================
  localparam logic [3:0] SBCS_ENC_NOP = 4'h7;
  localparam logic [3:0] SBCS_ENC_ACT = 4'h3;
  localparam logic [3:0] SBCS_ENC_RD = 4'h5;
  localparam logic [3:0] SBCS_ENC_WR = 4'h4;
  localparam logic [3:0] SBCS_ENC_PRE = 4'h2;
  localparam logic [3:0] SBCS_ENC_REF = 4'h1;
  localparam logic [3:0] SBCS_ENC_LMR = 4'h0;
  localparam logic [3:0] SBCS_ENC_BT = 4'h6;

  typedef enum {
    SBCS_CMD_INHIBIT, SBCS_CMD_NOP, SBCS_CMD_ACT, SBCS_CMD_RD, SBCS_CMD_WR,
    SBCS_CMD_PRE, SBCS_CMD_REF, SBCS_CMD_LMR, SBCS_CMD_BT
  } sbcs_cmd_t;

  // per-bank states
  typedef enum {
    SBCS_BK_IDLE, SBCS_BK_ACTIVATING, SBCS_BK_ACTIVE, SBCS_BK_READ, SBCS_BK_WRITE,
    SBCS_BK_READ_AP, SBCS_BK_WRITE_AP, SBCS_BK_RECOVER, SBCS_BK_PRECHARGING
  } sbcs_bank_t;

  // device-wide clock enable modes
  typedef enum {
    SBCS_MODE_RUN, SBCS_MODE_POWER_DOWN, SBCS_MODE_SELF_REFRESH,
    SBCS_MODE_SUSPEND, SBCS_MODE_XSR_WAIT
  } sbcs_mode_t;

  // command pins as one carrier
  typedef struct packed {
    logic sel_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic [SBCS_BANK_W-1:0] bank;
    logic [SBCS_ADDR_W-1:0] addr;
  } sbcs_cmd_pins_t;

  // decoder helper
  function automatic sbcs_cmd_t sbcs_decode(input sbcs_cmd_pins_t p);
    logic [3:0] enc;
    enc = {p.sel_n, p.row_strobe_n, p.col_strobe_n, p.write_enable_n};
    if (p.sel_n) begin
      return SBCS_CMD_INHIBIT;
    end
    case (enc)
      SBCS_ENC_NOP: return SBCS_CMD_NOP;
      SBCS_ENC_ACT: return SBCS_CMD_ACT;
      SBCS_ENC_RD: return SBCS_CMD_RD;
      SBCS_ENC_WR: return SBCS_CMD_WR;
      SBCS_ENC_PRE: return SBCS_CMD_PRE;
      SBCS_ENC_REF: return SBCS_CMD_REF;
      SBCS_ENC_LMR: return SBCS_CMD_LMR;
      default: return SBCS_CMD_BT;
    endcase
  endfunction

endpackage

// ==== testbench.sv ====
// testbench for the sdram bank command state tracker
// assumes the controller model drives every design input but clock and reset
module testbench
  import sbcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  sbcs_cmd_pins_t cmd_pins;
  logic clock_enable, data_mask, data_oe_n, wr_strobe, illegal_cmd, all_idle;
  logic [15:0] data_in, data_out, wr_data;
  logic [1:0] wr_bank;
  logic [2:0] mode_code;
  logic [17:0] wq[$]; // written bank and word
  logic [15:0] rq[$]; // read words seen while driven
  logic [7:0] seen_mode = 8'h00;
  int oe_cnt = 0, ill_cnt = 0, miscompares = 0, samples_checked = 0, i;
  sbcs_ctrl_model ctl (.sys_clk(sys_clk), .cmd_pins(cmd_pins), .clock_enable(clock_enable),
    .data_mask(data_mask), .data_in(data_in));
  sbcs_device dut (.sys_clk(sys_clk), .srst(srst), .cmd_pins(cmd_pins),
    .clock_enable(clock_enable), .data_mask(data_mask), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .wr_strobe(wr_strobe), .wr_bank(wr_bank),
    .wr_data(wr_data), .illegal_cmd(illegal_cmd), .all_idle(all_idle), .mode_code(mode_code));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ============================================================
  // monitor of outputs
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) wq.push_back({wr_bank, wr_data});
    if (data_oe_n === 1'b0) oe_cnt++;
    if (data_oe_n === 1'b0) rq.push_back(data_out);
    if (illegal_cmd === 1'b1) ill_cnt++;
    seen_mode[mode_code] = 1'b1;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic nops(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // bounded wait on mode, then on idle when m is 0
  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 60 && (mode_code !== m || (m == 3'h0 && all_idle !== 1'b1)); k++) nops(1);
    check("mode", {all_idle, mode_code}, {m == 3'h0, m});
    if (mode_code !== m) conclude();
  endtask
  task automatic sc_write_ap();
    wq.delete();
    ctl.issue(SBCS_ENC_ACT, 2'h0, 12'h012);
    ctl.issue(SBCS_ENC_ACT, 2'h1, 12'h034);
    nops(1);
    ctl.issue(SBCS_ENC_WR, 2'h0, 12'h400, 16'h1111);
    ctl.issue(SBCS_ENC_NOP, 2'h0, 12'h000, 16'h2222);
    ctl.issue(SBCS_ENC_WR, 2'h1, 12'h000, 16'h3333);
    for (i = 0; i < 3; i++) ctl.issue(SBCS_ENC_NOP, 2'h0, 12'h000, 16'(16'h1111 * (i + 4)));
    nops(8);
    check("words", wq.size(), 6);
    for (i = 0; i < 6; i++) check("word", wq[i], {1'b0, i > 1, 16'(16'h1111 * (i + 1))});
    ctl.issue(SBCS_ENC_PRE, 2'h0, 12'h400);
    nops(4);
    wait_mode(3'h0);
  endtask
  task automatic sc_read_ap();
    oe_cnt = 0;
    rq.delete();
    ctl.issue(SBCS_ENC_ACT, 2'h2, 12'h001);
    ctl.issue(SBCS_ENC_ACT, 2'h3, 12'h002);
    nops(1);
    ctl.issue(SBCS_ENC_RD, 2'h2, 12'h400);
    ctl.issue(SBCS_ENC_RD, 2'h3, 12'h000);
    nops(10);
    check("read words", oe_cnt, SBCS_BURST_LEN + 1);
    for (i = 0; i < 5; i++) check("read word", rq[i], i ? i - 1 : 16'h0400);
    oe_cnt = 0;
    wq.delete();
    ctl.issue(SBCS_ENC_ACT, 2'h0, 12'h003);
    ctl.mask_req = 1'b1;
    nops(1);
    ctl.issue(SBCS_ENC_RD, 2'h3, 12'h400);
    ctl.mask_req = 1'b0;
    ctl.issue(SBCS_ENC_WR, 2'h0, 12'h000, 16'h5a5a);
    nops(10);
    check("cut read", oe_cnt, 0);
    check("cut writes", wq.size(), SBCS_BURST_LEN);
    ctl.issue(SBCS_ENC_PRE, 2'h0, 12'h400);
    wait_mode(3'h0);
  endtask
  task automatic sc_illegal_power();
    ill_cnt = 0;
    oe_cnt = 0;
    ctl.issue(SBCS_ENC_RD, 2'h1, 12'h000);
    nops(6);
    check("illegal", {oe_cnt[3:0], ill_cnt[3:0], all_idle}, 9'h003);
    ctl.cke_req = 1'b0;
    wait_mode(3'h1);
    ctl.cke_req = 1'b1;
    wait_mode(3'h0);
    ctl.cke_req = 1'b0;
    ctl.issue(SBCS_ENC_REF, 2'h0, 12'h000);
    wait_mode(3'h2);
    seen_mode = 8'h00;
    ctl.cke_req = 1'b1;
    wait_mode(3'h0);
    check("exit wait", seen_mode[4], 1'b1);
  endtask
  task automatic sc_suspend();
    seen_mode = 8'h00;
    wq.delete();
    ctl.issue(SBCS_ENC_ACT, 2'h1, 12'h005);
    nops(1);
    ctl.issue(SBCS_ENC_WR, 2'h1, 12'h400, 16'h0f0f);
    ctl.cke_req = 1'b0;
    nops(2);
    ctl.cke_req = 1'b1;
    nops(10);
    check("suspend", seen_mode[3], 1'b1);
    check("frozen burst", wq.size(), SBCS_BURST_LEN);
    wait_mode(3'h0);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("reset", {all_idle, mode_code, data_oe_n, wr_strobe}, 6'h22);
    sc_write_ap();
    sc_read_ap();
    sc_illegal_power();
    sc_suspend();
    conclude();
  end
endmodule
